// *** logic/ssc_pkg.sv ***
package ssc_pkg;
    // ------------------------------------------------------------
    // attribute bus shape
    // ------------------------------------------------------------
    localparam int ATTR_W = 8;
    localparam int DATA_W = 16;
    localparam int TRIP_N = 16;

    // ------------------------------------------------------------
    // attribute numbers
    // ------------------------------------------------------------
    localparam logic [ATTR_W-1:0] A_FAULT_EN = 8'h64;
    localparam logic [ATTR_W-1:0] A_TRIP = 8'h66;
    localparam logic [ATTR_W-1:0] A_STATUS = 8'h67;
    localparam logic [ATTR_W-1:0] A_WDOG = 8'h69;
    localparam logic [ATTR_W-1:0] A_LOSS = 8'h6a;
    localparam logic [ATTR_W-1:0] A_CMD = 8'h96;
    localparam logic [ATTR_W-1:0] A_START = 8'h97;
    localparam logic [ATTR_W-1:0] A_RELAY = 8'h98;

    // ------------------------------------------------------------
    // reset values (stored copies are reloaded by firmware)
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
    localparam logic [DATA_W-1:0] RST_FAULT_EN = 16'h7fff;

    // ------------------------------------------------------------
    // fault enable bits
    // ------------------------------------------------------------
    localparam int FE_SHARED_N = 6; // bits 0..5 match trip bits 0..5
    localparam int FE_UNDERV = 6;
    localparam int FE_OVERV = 7;
    localparam int FE_VUNBAL = 8;
    localparam int FE_PHREV = 9;
    localparam int FE_GROUND = 10;
    localparam int FE_OL_START = 11;
    localparam int FE_SHORTED = 12;
    localparam int FE_NOFIRE = 13;
    localparam int FE_OVERTEMP = 14;

    // ------------------------------------------------------------
    // trip reason bits
    // ------------------------------------------------------------
    localparam int TR_OVERLOAD = 0;
    localparam int TR_PHLOSS = 5;
    localparam int TR_MAINS = 6;
    localparam int TR_PHREV = 7;
    localparam int TR_SHORTED = 8;
    localparam int TR_NOFIRE = 9;
    localparam int TR_POLETEMP = 10;
    localparam int TR_COMM = 14;

    // ------------------------------------------------------------
    // motor status and command bits
    // ------------------------------------------------------------
    localparam int ST_RUN = 0;
    localparam int ST_BYPASS = 2;
    localparam int ST_FAULT = 5;
    localparam int ST_RELAY1 = 11;
    localparam int ST_RELAY2 = 12;
    localparam int ST_NETCTL = 13;
    localparam int ST_PERMIT = 14;
    localparam int CMD_RUN = 0;
    localparam int CMD_PERMIT = 2;
    localparam int CMD_RESET = 3;

    // ------------------------------------------------------------
    // setting codes
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] WDOG_ON = 16'h0001;
    localparam logic [DATA_W-1:0] LOSS_FAULT = 16'h0001;
    localparam logic [DATA_W-1:0] LOSS_HOLD = 16'h0002;
    localparam logic [DATA_W-1:0] LOSS_STOP = 16'h0003;
    localparam logic [DATA_W-1:0] START_EDGE = 16'h0000;
    localparam logic [DATA_W-1:0] START_LEVEL = 16'h0001;
    localparam logic [DATA_W-1:0] RELAY_ON_FAULT = 16'h0000;
endpackage : ssc_pkg

// *** logic/ssc_sync3.sv ***
`timescale 1ns/1ps
`default_nettype none
// three-stage pin synchroniser; level moves once stages two and three agree
module ssc_sync3 (
    // clock and control
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // pin and clean level
    input wire logic i_pin,
    output logic o_level
);
    logic s1, s2, s3, lvl;
    logic next_s1, next_s2, next_s3, next_lvl;

    // stage one is read only by stage two
    always_comb begin
        next_s1 = i_pin;
        next_s2 = s1;
        next_s3 = s2;
        next_lvl = (s2 == s3) ? s3 : lvl;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            lvl <= 1'b0;
        end else if (i_ce) begin
            s1 <= next_s1;
            s2 <= next_s2;
            s3 <= next_s3;
            lvl <= next_lvl;
        end
    end

    assign o_level = lvl;
endmodule : ssc_sync3
`default_nettype wire

// *** logic/ssc_supervisor.sv ***
// What this block does
// - fault enable bits 0..10 for named faults
// - fault enable bits 11..14 for thyristor faults
// - status shows run, bypass, fault bits
// - status shows relays, network control, permissive
// - watchdog enable turns timeout supervision on
// - comm loss: fault, hold, or stop
// - edge mode starts on rising start input
// - level mode runs while start input high
// - fault relay polarity from configuration
// - trip bits 4..15 name later faults
// - trip bits 0..3 overload, jam, stall, imbalance
`timescale 1ns/1ps
`default_nettype none
module ssc_supervisor
    import ssc_pkg::*;
(
    // clock and control
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // attribute access
    input wire logic [ATTR_W-1:0] i_attr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [DATA_W-1:0] i_wr_data,
    output logic [DATA_W-1:0] o_rd_data,
    output logic o_ack,
    output logic o_err,
    // starter side
    input wire logic [TRIP_N-1:0] i_fault_event,
    input wire logic i_comm_lost,
    input wire logic i_bypass,
    input wire logic i_relay2,
    input wire logic i_start_pin,
    input wire logic i_permit_pin,
    output logic o_motor_run,
    output logic o_fault_relay
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic start_lvl, permit_lvl;

    ssc_sync3 u_start_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_pin(i_start_pin),
        .o_level(start_lvl)
    );

    ssc_sync3 u_permit_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_pin(i_permit_pin),
        .o_level(permit_lvl)
    );

    // ------------------------------------------------------------
    // attribute storage
    // ------------------------------------------------------------
    logic [DATA_W-1:0] fault_en, wdog, loss, cmd, start_mode, relay_pol;
    logic [DATA_W-1:0] next_fault_en, next_wdog, next_loss, next_cmd;
    logic [DATA_W-1:0] next_start_mode, next_relay_pol;
    logic [DATA_W-1:0] rd_data, next_rd_data, status;
    logic [TRIP_N-1:0] trip, next_trip, gate, set_vec;
    logic ack, err, next_ack, next_err, hit, ro;

    // decode; writes to read-only or unknown attributes answer an error
    always_comb begin
        hit = 1'b1;
        ro = 1'b0;
        next_rd_data = rd_data;
        if (i_attr == A_FAULT_EN) begin
            next_rd_data = fault_en;
        end else if (i_attr == A_TRIP) begin
            next_rd_data = trip;
            ro = 1'b1;
        end else if (i_attr == A_STATUS) begin
            next_rd_data = status;
            ro = 1'b1;
        end else if (i_attr == A_WDOG) begin
            next_rd_data = wdog;
        end else if (i_attr == A_LOSS) begin
            next_rd_data = loss;
        end else if (i_attr == A_CMD) begin
            next_rd_data = cmd;
        end else if (i_attr == A_START) begin
            next_rd_data = start_mode;
        end else if (i_attr == A_RELAY) begin
            next_rd_data = relay_pol;
        end else begin
            hit = 1'b0;
            next_rd_data = RST_WORD;
        end
        if (!i_rd) begin
            next_rd_data = rd_data;
        end
        next_ack = i_rd | i_wr;
        next_err = (i_rd & ~hit) | (i_wr & (~hit | ro));
        next_fault_en = fault_en;
        next_wdog = wdog;
        next_loss = loss;
        next_cmd = cmd;
        next_start_mode = start_mode;
        next_relay_pol = relay_pol;
        if (i_wr && i_attr == A_FAULT_EN) next_fault_en = i_wr_data;
        if (i_wr && i_attr == A_WDOG) next_wdog = i_wr_data;
        if (i_wr && i_attr == A_LOSS) next_loss = i_wr_data;
        if (i_wr && i_attr == A_CMD) next_cmd = i_wr_data;
        if (i_wr && i_attr == A_START) next_start_mode = i_wr_data;
        if (i_wr && i_attr == A_RELAY) next_relay_pol = i_wr_data;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            fault_en <= RST_FAULT_EN;
            wdog <= RST_WORD;
            loss <= RST_WORD;
            cmd <= RST_WORD;
            start_mode <= RST_WORD;
            relay_pol <= RST_WORD;
            rd_data <= RST_WORD;
            ack <= 1'b0;
            err <= 1'b0;
        end else if (i_ce) begin
            fault_en <= next_fault_en;
            wdog <= next_wdog;
            loss <= next_loss;
            cmd <= next_cmd;
            start_mode <= next_start_mode;
            relay_pol <= next_relay_pol;
            rd_data <= next_rd_data;
            ack <= next_ack;
            err <= next_err;
        end
    end

    // ------------------------------------------------------------
    // trip capture and motor control
    // ------------------------------------------------------------
    logic run_latch, next_run_latch, held, next_held;
    logic run, next_run, relay, next_relay, start_prev, next_start_prev;
    logic lost, comm_trip, net_run, perm_ok, faulted, start_rise;

    assign faulted = |trip;
    assign lost = (wdog == WDOG_ON) & i_comm_lost;
    assign comm_trip = lost & (loss == LOSS_FAULT);
    assign perm_ok = permit_lvl & cmd[CMD_PERMIT];
    assign start_rise = start_lvl & ~start_prev;

    // faults with no enable bit of their own are always armed
    always_comb begin
        gate = {TRIP_N{1'b1}};
        for (int k = 0; k < FE_SHARED_N; k++) begin
            gate[k] = fault_en[k];
        end
        gate[TR_MAINS] = fault_en[FE_UNDERV] | fault_en[FE_OVERV]
                       | fault_en[FE_VUNBAL];
        gate[TR_PHREV] = fault_en[FE_PHREV];
        gate[TR_SHORTED] = fault_en[FE_SHORTED];
        gate[TR_NOFIRE] = fault_en[FE_NOFIRE];
        gate[TR_POLETEMP] = fault_en[FE_OVERTEMP];
        set_vec = i_fault_event & gate;
        set_vec[TR_COMM] = set_vec[TR_COMM] | comm_trip;
    end

    // sticky trips; a new event wins over a reset request
    always_comb begin
        next_trip = trip;
        if (cmd[CMD_RESET]) next_trip = '0;
        next_trip = next_trip | set_vec;
        // hold keeps the network run request seen before the loss
        next_held = lost ? held : cmd[CMD_RUN];
        if (lost) begin
            net_run = (loss == LOSS_HOLD) ? held : 1'b0;
        end else begin
            net_run = cmd[CMD_RUN];
        end
        if (start_mode == START_LEVEL) begin
            next_run_latch = start_lvl;
        end else if (faulted || !perm_ok) begin
            next_run_latch = 1'b0;
        end else begin
            next_run_latch = run_latch | start_rise;
        end
        next_run = perm_ok & ~faulted & (net_run | run_latch);
        next_start_prev = start_lvl;
        // relay polarity: 0 energises on fault, else when healthy
        next_relay = (relay_pol == RELAY_ON_FAULT) ? faulted : ~faulted;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            trip <= '0;
            held <= 1'b0;
            run_latch <= 1'b0;
            run <= 1'b0;
            relay <= 1'b0;
            start_prev <= 1'b0;
        end else if (i_ce) begin
            trip <= next_trip;
            held <= next_held;
            run_latch <= next_run_latch;
            run <= next_run;
            relay <= next_relay;
            start_prev <= next_start_prev;
        end
    end

    // status word built live from block state
    always_comb begin
        status = '0;
        status[ST_RUN] = run;
        status[ST_BYPASS] = i_bypass;
        status[ST_FAULT] = faulted;
        status[ST_RELAY1] = relay;
        status[ST_RELAY2] = i_relay2;
        status[ST_NETCTL] = ~lost;
        status[ST_PERMIT] = permit_lvl;
    end

    assign o_rd_data = rd_data;
    assign o_ack = ack;
    assign o_err = err;
    assign o_motor_run = run;
    assign o_fault_relay = relay;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    fault_en_wr_a: assert property (i_ce && i_wr && i_attr == A_FAULT_EN
        |=> fault_en == $past(i_wr_data)) else $error("fault enable lost");
    trip_gated_a: assert property (i_ce && !fault_en[TR_OVERLOAD]
        && !trip[TR_OVERLOAD] |=> !trip[TR_OVERLOAD])
        else $error("disabled trip set");
    trip_set_a: assert property (i_ce && i_fault_event[TR_PHLOSS]
        && fault_en[TR_PHLOSS] |=> trip[TR_PHLOSS])
        else $error("enabled trip missed");
    trip_sticky_a: assert property (i_ce && trip[TR_SHORTED]
        && !cmd[CMD_RESET] |=> trip[TR_SHORTED])
        else $error("trip not sticky");
    comm_trip_a: assert property (i_ce && comm_trip
        |=> trip[TR_COMM]) else $error("comm fault not tripped");
    comm_stop_a: assert property (i_ce && lost && loss == LOSS_STOP
        && !run_latch |=> !run) else $error("comm stop ignored");
    wdog_off_a: assert property (i_ce && wdog != WDOG_ON
        && !trip[TR_COMM] && !i_fault_event[TR_COMM] |=> !trip[TR_COMM])
        else $error("timeout while disabled");
    edge_start_a: assert property (i_ce && start_mode == START_EDGE
        && !start_rise && !run_latch |=> !run_latch)
        else $error("start without edge");
    level_run_a: assert property (i_ce && start_mode == START_LEVEL
        && start_lvl |=> run_latch) else $error("level start missed");
    relay_pol_a: assert property (i_ce |=> o_fault_relay ==
        ($past(relay_pol) == RELAY_ON_FAULT ? $past(faulted)
        : !$past(faulted))) else $error("fault relay wrong");
    status_rd_a: assert property (i_ce && i_rd && i_attr == A_STATUS
        |=> o_ack && o_rd_data[ST_FAULT] == $past(faulted))
        else $error("status read wrong");

    edge_start_c: cover property (i_ce && start_rise ##1 run_latch);
    comm_trip_c: cover property (comm_trip ##1 trip[TR_COMM]);
    trip_reset_c: cover property (faulted ##1 cmd[CMD_RESET] ##1 !faulted);
    bad_attr_c: cover property (o_err);
endmodule : ssc_supervisor
`default_nettype wire

// *** tb/ssc_ctl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// network controller: one attribute access at a time
// ---------------------------------------------
module ssc_ctl_model
    import ssc_pkg::*;
(
    // clock
    input wire logic i_ref_clk,
    // attribute access out
    output logic [ATTR_W-1:0] o_attr,
    output logic o_rd,
    output logic o_wr,
    output logic [DATA_W-1:0] o_wr_data,
    // answer in
    input wire logic [DATA_W-1:0] i_rd_data,
    input wire logic i_ack,
    input wire logic i_err
);
    // idle bus at time zero
    initial begin
        o_attr = '0;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_wr_data = '0;
    end

    // request stands until the ack edge; a repeated take is harmless
    // since the same word goes again; released lines show inverted junk
    task automatic acc(input logic w, input logic [ATTR_W-1:0] a,
        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
        output logic e);
        int n;
        @(posedge i_ref_clk);
        o_attr <= a;
        o_wr <= w;
        o_rd <= !w;
        o_wr_data <= d;
        n = 0;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (!i_ack && n < 4);
        e = i_ack ? i_err : 1'bx; // a missing ack reads as unknown
        q = i_ack ? i_rd_data : 'x;
        o_wr <= 1'b0;
        o_rd <= 1'b0;
        o_attr <= ~a;
        o_wr_data <= ~d;
    endtask : acc
endmodule : ssc_ctl_model
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
    err_count++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
    import ssc_pkg::*;
    // ---------------------------------------------
    // signals and reference state
    // ---------------------------------------------
    logic clk = 0, rst = 1, lost = 0, bp = 0, r2 = 0, st = 0, pm = 0;
    logic ce = 1;
    logic [15:0] ev = '0;
    logic [7:0] attr;
    logic rd_s, wr_s, ack, err, run, rly;
    logic [15:0] wd, rdat;
    int err_count = 0, num_checks = 0, fe, trip = 0, rp = 0, x;
    logic [7:0] rw[5] = '{A_WDOG, A_LOSS, A_CMD, A_START, A_RELAY};

    always #5 clk = ~clk;

    ssc_supervisor ssc_supervisor_i (.i_ref_clk(clk), .i_rst(rst),
        .i_ce(ce), .i_attr(attr), .i_rd(rd_s), .i_wr(wr_s),
        .i_wr_data(wd), .o_rd_data(rdat), .o_ack(ack), .o_err(err),
        .i_fault_event(ev), .i_comm_lost(lost), .i_bypass(bp),
        .i_relay2(r2), .i_start_pin(st), .i_permit_pin(pm),
        .o_motor_run(run), .o_fault_relay(rly));
    ssc_ctl_model ssc_ctl_model_i (.i_ref_clk(clk), .o_attr(attr),
        .o_rd(rd_s), .o_wr(wr_s), .o_wr_data(wd), .i_rd_data(rdat),
        .i_ack(ack), .i_err(err));

    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    function automatic int gate(input int f);
        return (f & 'h3f) | 'hf800 | (int'((f & 'h1c0) != 0) << 6)
            | (((f >> 9) & 1) << 7) | (((f >> 12) & 7) << 8);
    endfunction : gate

    task automatic rd(input logic [7:0] a, input int v, input logic xe);
        logic [15:0] q;
        logic e;
        ssc_ctl_model_i.acc(1'b0, a, 16'h0, q, e);
        `CHK("rd_err", xe, e)
        `CHK("rd_data", v[15:0], q)
    endtask : rd

    task automatic wr(input logic [7:0] a, input int d, input logic xe);
        logic [15:0] q;
        logic e;
        ssc_ctl_model_i.acc(1'b1, a, d[15:0], q, e);
        `CHK("wr_err", xe, e)
    endtask : wr

    // status word built from the model; relay follows polarity
    task automatic chk_st(input logic r, input logic nl);
        logic f, rl, b, a2;
        f = (trip != 0);
        rl = (rp == 0) ? f : !f;
        b = 1'($urandom);
        a2 = 1'($urandom);
        @(posedge clk);
        bp <= b;
        r2 <= a2;
        `CHK("motor_run", r, run)
        `CHK("fault_relay", rl, rly)
        rd(A_STATUS, {1'b0, pm, nl, a2, rl, 5'h0, f, 2'h0, b, 1'b0, r},
            1'b0);
    endtask : chk_st

    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // hang guard, far beyond the several hundred cycles used
    initial begin
        #200us;
        err_count++;
        give_verdict();
    end

    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        x = $urandom(45788);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rd(A_FAULT_EN, 'h7fff, 1'b0);
        foreach (rw[i]) begin
            x = $urandom & 'hffff;
            rd(rw[i], 0, 1'b0);
            wr(rw[i], x, 1'b0);
            rd(rw[i], x, 1'b0);
            wr(rw[i], 0, 1'b0);
        end
        wr(A_STATUS, 'h1234, 1'b1);
        wr(A_TRIP, 'h1234, 1'b1);
        wr(8'h00, 'h1234, 1'b1);
        rd(8'h00, 0, 1'b1);
        // each trip bit against a random enable mask
        for (int i = 0; i < 16; i++) begin
            fe = $urandom & 'h7fff;
            wr(A_FAULT_EN, fe, 1'b0);
            rd(A_FAULT_EN, fe, 1'b0);
            @(posedge clk) ev <= 16'(1 << i);
            @(posedge clk) ev <= '0;
            trip = (1 << i) & gate(fe);
            rd(A_TRIP, trip, 1'b0);
            wr(A_CMD, 8, 1'b0);
            wr(A_CMD, 0, 1'b0);
            trip = 0;
            rd(A_TRIP, 0, 1'b0);
        end
        // start input: edge then level
        wr(A_CMD, 4, 1'b0);
        @(posedge clk) pm <= 1'b1;
        repeat (8) @(posedge clk);
        chk_st(1'b0, 1'b1);
        @(posedge clk) st <= 1'b1;
        repeat (8) @(posedge clk);
        chk_st(1'b1, 1'b1);
        @(posedge clk) st <= 1'b0;
        repeat (8) @(posedge clk);
        chk_st(1'b1, 1'b1);
        @(posedge clk) pm <= 1'b0;
        repeat (8) @(posedge clk);
        @(posedge clk) st <= 1'b1;
        repeat (8) @(posedge clk);
        @(posedge clk) pm <= 1'b1;
        repeat (8) @(posedge clk);
        chk_st(1'b0, 1'b1);
        wr(A_START, 1, 1'b0);
        repeat (4) @(posedge clk);
        chk_st(1'b1, 1'b1);
        @(posedge clk) st <= 1'b0;
        repeat (8) @(posedge clk);
        chk_st(1'b0, 1'b1);
        // network run and communication loss codes
        rp = $urandom & 1;
        wr(A_RELAY, rp, 1'b0);
        wr(A_CMD, 5, 1'b0);
        repeat (4) @(posedge clk);
        chk_st(1'b1, 1'b1);
        wr(A_WDOG, 1, 1'b0);
        wr(A_LOSS, 3, 1'b0);
        @(posedge clk) lost <= 1'b1;
        repeat (4) @(posedge clk);
        chk_st(1'b0, 1'b0);
        @(posedge clk) lost <= 1'b0;
        wr(A_LOSS, 2, 1'b0);
        @(posedge clk) lost <= 1'b1;
        repeat (4) @(posedge clk);
        chk_st(1'b1, 1'b0);
        wr(A_LOSS, 1, 1'b0);
        repeat (4) @(posedge clk);
        trip = 1 << TR_COMM;
        rd(A_TRIP, trip, 1'b0);
        chk_st(1'b0, 1'b0);
        wr(A_WDOG, 0, 1'b0);
        wr(A_CMD, 13, 1'b0);
        wr(A_CMD, 5, 1'b0);
        trip = 0;
        repeat (4) @(posedge clk);
        chk_st(1'b1, 1'b1);
        // frozen block ignores an always-armed fault and holds its run
        @(posedge clk) begin
            ce <= 1'b0;
            ev <= 16'h8000;
        end
        repeat (4) @(posedge clk);
        `CHK("frozen_run", 1'b1, run)
        @(posedge clk) begin
            ce <= 1'b1;
            ev <= '0;
        end
        rd(A_TRIP, 0, 1'b0);
        // other relay polarity while healthy
        rp = 1 - rp;
        wr(A_RELAY, rp, 1'b0);
        chk_st(1'b1, 1'b1);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
